// *** hw/stc_regs.sv ***
// Configuration register, fault filter and fan period readout
`timescale 1ns/100ps
`default_nettype none

module stc_regs
	import stc_pkg::*;
(
	input wire logic clk_sys, // System clock, 125 MHz
	input wire logic sys_rst, // Synchronous reset, active high
	input wire stc_pkg::stc_req_t req, // Decoded byte access from the serial front end
	output logic [7:0] rdata, // Read data, valid the cycle after rd
	input wire stc_pkg::stc_conv_t conv, // Remote conversion result and limits
	output logic conv_run, // Continuous conversion enable
	output logic one_shot, // Single conversion start pulse
	output logic [7:0] crit_limit, // Active critical limit
	input wire logic pwm_in, // Fan waveform from the PWM generator
	input wire logic pwm_pol, // PWM polarity: level of the off state
	output logic pwm_out, // PWM output
	input wire logic pin_in, // Shared fault/tach pin, input path
	output logic pin_out, // Shared pin, output level
	output logic pin_oe // Shared pin, drive enable
);
	import stc_pkg::*;

	stc_state_t s_r;
	stc_state_t s_nxt;

	function automatic logic out_of_range(input stc_conv_t c);
		out_of_range = ($signed(c.temp) > $signed(c.high_lim)) || ($signed(c.temp) < $signed(c.low_lim));
	endfunction

	logic wr_cfg;
	logic tach_rise;

	always_comb begin
		s_nxt = s_r;
		wr_cfg = req.wr && (req.addr == STC_ADDR_CFG || req.addr == STC_ADDR_CFG_ALT);
		s_nxt.one_shot = 1'b0;
		if (wr_cfg) begin
			s_nxt.cfg = req.wdata & STC_CFG_WMASK;
		end
		// Unlock must already be set before the limit write lands
		if (req.wr && req.addr == STC_ADDR_CRIT && s_r.cfg[STC_CFG_CRIT_UNLOCK] && !s_r.crit_used) begin
			s_nxt.crit = req.wdata;
			s_nxt.crit_used = 1'b1;
		end
		if (req.wr && req.addr == STC_ADDR_ONE_SHOT && s_r.cfg[STC_CFG_STANDBY]) begin
			s_nxt.one_shot = 1'b1;
		end
		s_nxt.conv_run = !s_r.cfg[STC_CFG_STANDBY];

		// Fault evaluation per conversion; a clean result clears the streak
		if (conv.done) begin
			if (out_of_range(conv)) begin
				if (s_r.oor_cnt != STC_FILTER_DEPTH) begin
					s_nxt.oor_cnt = s_r.oor_cnt + 2'h1;
				end
				if (!s_r.cfg[STC_CFG_FAULT_FILTER]) begin
					s_nxt.fault = 1'b1;
				end else if (s_r.oor_cnt >= STC_FILTER_DEPTH - 2'h1) begin
					s_nxt.fault = 1'b1;
				end
			end else begin
				s_nxt.oor_cnt = 2'h0;
				s_nxt.fault = 1'b0;
			end
		end

		// Fault pin never driven high: open drain
		s_nxt.pin_out = 1'b0;
		s_nxt.pin_oe = s_r.fault && !s_r.cfg[STC_CFG_FAULT_MASK] && !s_r.cfg[STC_CFG_PIN_TACH];

		if (s_r.cfg[STC_CFG_STANDBY] && s_r.cfg[STC_CFG_PWM_OFF_STBY]) begin
			s_nxt.pwm_out = pwm_pol;
		end else begin
			s_nxt.pwm_out = pwm_in;
		end

		// Tach period: ticks between rising edges, saturating
		s_nxt.tach_sync = {s_r.tach_sync[0], pin_in};
		s_nxt.tach_prev = s_r.tach_sync[1];
		tach_rise = s_r.cfg[STC_CFG_PIN_TACH] && s_r.tach_sync[1] && !s_r.tach_prev;
		s_nxt.tick_cnt = (s_r.tick_cnt == STC_TACH_TICK_CYC - 8'h1) ? 8'h00 : s_r.tick_cnt + 8'h1;
		if (tach_rise) begin
			s_nxt.tach_val = s_r.period_cnt;
			s_nxt.period_cnt = 16'h0000;
			s_nxt.tick_cnt = 8'h00;
		end else if (s_r.tick_cnt == STC_TACH_TICK_CYC - 8'h1 && s_r.period_cnt != 16'hffff) begin
			s_nxt.period_cnt = s_r.period_cnt + 16'h1;
		end

		// Hold moves only on a low read, so a late high read stays coherent
		s_nxt.rdata = 8'h00;
		if (req.rd) begin
			case (req.addr)
				STC_ADDR_CFG, STC_ADDR_CFG_ALT: s_nxt.rdata = s_r.cfg;
				STC_ADDR_CRIT: s_nxt.rdata = s_r.crit;
				STC_ADDR_TACH_LO: begin
					s_nxt.rdata = s_r.tach_val[7:0];
					s_nxt.tach_hi_hold = s_r.tach_val[15:8];
				end
				STC_ADDR_TACH_HI: s_nxt.rdata = s_r.tach_hi_hold;
				default: s_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			s_r <= '0;
			s_r.cfg <= STC_CFG_RST;
			s_r.crit <= STC_CRIT_RST;
			s_r.tach_val <= STC_TACH_RST;
			s_r.tach_hi_hold <= STC_TACH_RST[15:8];
			s_r.conv_run <= 1'b1;
			// Start at the pin's idle level so reset gives no false tach edge
			s_r.tach_sync <= {2{STC_PIN_IDLE}};
			s_r.tach_prev <= STC_PIN_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata = s_r.rdata;
	assign conv_run = s_r.conv_run;
	assign one_shot = s_r.one_shot;
	assign crit_limit = s_r.crit;
	assign pwm_out = s_r.pwm_out;
	assign pin_out = s_r.pin_out;
	assign pin_oe = s_r.pin_oe;

	// Pin, mode, config readback and critical limit checks, one cycle after the state that decides them
	AST_MASK_RELEASE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_r.cfg[STC_CFG_FAULT_MASK] |=> !pin_oe)
		else $error("fault pin driven while masked");

	AST_RUN_FOLLOWS: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!s_r.cfg[STC_CFG_STANDBY] |=> conv_run)
		else $error("conversions stopped in operational mode");

	AST_ONE_SHOT: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(req.wr && req.addr == STC_ADDR_ONE_SHOT && s_r.cfg[STC_CFG_STANDBY]) |=> one_shot ##1 !one_shot)
		else $error("one-shot write gave no single pulse");

	AST_ONE_SHOT_IDLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(req.wr && req.addr == STC_ADDR_ONE_SHOT && !s_r.cfg[STC_CFG_STANDBY]) |=> !one_shot)
		else $error("one-shot pulse outside standby");

	AST_PWM_STBY: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(s_r.cfg[STC_CFG_STANDBY] && !s_r.cfg[STC_CFG_PWM_OFF_STBY]) |=> pwm_out == $past(pwm_in))
		else $error("pwm waveform not passed in standby");

	AST_PWM_OFF: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(s_r.cfg[STC_CFG_STANDBY] && s_r.cfg[STC_CFG_PWM_OFF_STBY]) |=> pwm_out == $past(pwm_pol))
		else $error("pwm not at off level in standby");

	AST_UNUSED_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(req.rd && req.addr == STC_ADDR_CFG) |=> rdata[4:3] == 2'b00)
		else $error("unused config bits read nonzero");

	AST_TACH_RELEASED: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_r.cfg[STC_CFG_PIN_TACH] |=> !pin_oe)
		else $error("pin driven in tach mode");

	AST_CRIT_ONCE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_r.crit_used |=> $stable(crit_limit))
		else $error("critical limit changed twice");

	AST_CRIT_REFUSED: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(req.wr && req.addr == STC_ADDR_CRIT && !s_r.cfg[STC_CFG_CRIT_UNLOCK]) |=> $stable(crit_limit))
		else $error("critical limit changed while locked");

	// Fault filter checks
	AST_SINGLE_FAULT: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(conv.done && out_of_range(conv) && !s_r.cfg[STC_CFG_FAULT_FILTER]) |=> s_r.fault)
		else $error("single out-of-range missed");

	AST_CLEAN_CLEARS: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(conv.done && !out_of_range(conv)) |=> !s_r.fault && s_r.oor_cnt == 2'h0)
		else $error("in-range result left fault or streak");

	AST_FILTER: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(conv.done && s_r.cfg[STC_CFG_FAULT_FILTER] && !s_r.fault && s_r.oor_cnt == 2'h0) |=> !s_r.fault)
		else $error("filtered fault raised early");

	AST_FILTER_THIRD: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(conv.done && out_of_range(conv) && s_r.cfg[STC_CFG_FAULT_FILTER] && s_r.oor_cnt == 2'h2) |=> s_r.fault)
		else $error("third out-of-range missed");

	// Fan period checks, then the fault pin drive check
	AST_TACH_CAPTURE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		tach_rise |=> s_r.tach_val == $past(s_r.period_cnt))
		else $error("period not captured on tach edge");

	AST_PERIOD_SAT: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(s_r.period_cnt == 16'hffff && !tach_rise) |=> s_r.period_cnt == 16'hffff)
		else $error("period counter wrapped");

	AST_LO_READ: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(req.rd && req.addr == STC_ADDR_TACH_LO) |=> rdata == $past(s_r.tach_val[7:0]))
		else $error("low byte read wrong");

	AST_HI_LOCK: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(req.rd && req.addr == STC_ADDR_TACH_LO) ##1 (req.rd && req.addr == STC_ADDR_TACH_HI)
		|=> rdata == $past(s_r.tach_val[15:8], 2))
		else $error("high byte not coherent with low byte");

	AST_PIN_DRIVE: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(s_r.fault && !s_r.cfg[STC_CFG_FAULT_MASK] && !s_r.cfg[STC_CFG_PIN_TACH]) |=> pin_oe && !pin_out)
		else $error("pending fault not driven low");
endmodule

`default_nettype wire

// *** hw/stc_pkg.sv ***
// Constants and types for the sensor configuration and fan period readout block
package stc_pkg;
	// Register byte addresses
	localparam logic [7:0] STC_ADDR_CFG = 8'h03;
	localparam logic [7:0] STC_ADDR_CFG_ALT = 8'h09;
	localparam logic [7:0] STC_ADDR_ONE_SHOT = 8'h0f;
	localparam logic [7:0] STC_ADDR_CRIT = 8'h19;
	localparam logic [7:0] STC_ADDR_TACH_LO = 8'h46;
	localparam logic [7:0] STC_ADDR_TACH_HI = 8'h47;
	// Configuration field positions
	localparam int STC_CFG_FAULT_MASK = 7;
	localparam int STC_CFG_STANDBY = 6;
	localparam int STC_CFG_PWM_OFF_STBY = 5;
	localparam int STC_CFG_PIN_TACH = 2;
	localparam int STC_CFG_CRIT_UNLOCK = 1;
	localparam int STC_CFG_FAULT_FILTER = 0;
	localparam logic [7:0] STC_CFG_WMASK = 8'he7;
	// Reset values
	localparam logic [7:0] STC_CFG_RST = 8'h00;
	localparam logic [7:0] STC_CRIT_RST = 8'h55;
	localparam logic [15:0] STC_TACH_RST = 16'hffff;
	// Idle level of the shared pin, held up by its pull-up
	localparam logic STC_PIN_IDLE = 1'b1;
	// Fault filter depth in consecutive conversions
	localparam logic [1:0] STC_FILTER_DEPTH = 2'h3;
	// Tachometer period counter resolution
	localparam int STC_CLK_PERIOD_NS = 8;
	localparam int STC_TACH_TICK_NS = 1000;
	localparam logic [7:0] STC_TACH_TICK_CYC = 8'(STC_TACH_TICK_NS / STC_CLK_PERIOD_NS);

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} stc_req_t;

	typedef struct packed {
		logic done;
		logic [7:0] temp;
		logic [7:0] high_lim;
		logic [7:0] low_lim;
	} stc_conv_t;

	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] crit;
		logic crit_used;
		logic [1:0] oor_cnt;
		logic fault;
		logic [1:0] tach_sync;
		logic tach_prev;
		logic [7:0] tick_cnt;
		logic [15:0] period_cnt;
		logic [15:0] tach_val;
		logic [7:0] tach_hi_hold;
		logic [7:0] rdata;
		logic conv_run;
		logic one_shot;
		logic pwm_out;
		logic pin_oe;
		logic pin_out;
	} stc_state_t;
endpackage

// *** bench/stc_host_model.sv ***
// Register bus host model issuing byte accesses
`timescale 1ns/100ps
`default_nettype none
module stc_host_model (
	input wire logic clk_sys, // System clock
	output var stc_pkg::stc_req_t req, // Byte access request
	input wire logic [7:0] rdata // Read data
);
	import stc_pkg::*;
	initial req = '0;
	// Requests change only at the falling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys) req = '{1'b1, 1'b0, a, d};
		@(negedge clk_sys) req = '0;
	endtask
	// Data is registered, so it is taken one cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys) req = '{1'b0, 1'b1, a, 8'h00};
		@(negedge clk_sys) d = rdata;
		req = '0;
	endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the configuration and fan period block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import stc_pkg::*;
	logic clk_sys, sys_rst, pwm_in, pwm_pol, fan, conv_run, one_shot, pwm_out, pin_out, pin_oe;
	stc_req_t req;
	stc_conv_t conv;
	logic [7:0] rdata, crit_limit, v, w;
	logic [7:0] modes[4] = '{8'h00, 8'h01, 8'h80, 8'h04};
	int miscompares = 0;
	int checked = 0;
	// Open-drain wire with pull-up, shared with the fan sensor
	wire pin_in = pin_oe ? 1'b0 : fan;
	stc_regs i_stc_regs (.clk_sys, .sys_rst, .req, .rdata, .conv, .conv_run, .one_shot, .crit_limit,
		.pwm_in, .pwm_pol, .pwm_out, .pin_in, .pin_out, .pin_oe);
	stc_host_model i_stc_host_model (.clk_sys, .req, .rdata);
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic cv(input logic [7:0] t);
		@(negedge clk_sys) conv = '{1'b1, t, 8'h50, 8'h10};
		@(negedge clk_sys) conv.done = 1'b0;
	endtask
	// Generous bound: the tests need about 10k cycles
	initial begin
		#200000;
		miscompares++;
		results();
	end
	initial begin
		void'($urandom(32'h263042ce));
		{sys_rst, fan, pwm_in, pwm_pol} = 4'hc;
		conv = '0;
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys) sys_rst = 1'b0;
		i_stc_host_model.rd(STC_ADDR_CFG, v);
		chk(v, STC_CFG_RST);
		i_stc_host_model.rd(STC_ADDR_CRIT, v);
		chk(v, 8'h55);
		i_stc_host_model.rd(STC_ADDR_TACH_LO, v);
		chk(v, 8'hff);
		$display("Test reset values done");
		for (int i = 0; i < 12; i++) begin
			w = (i < 4) ? {1'b0, 1'b1, i[0], 5'h1f} : 8'($urandom);
			{pwm_in, pwm_pol} = 2'($urandom);
			i_stc_host_model.wr(i[1] ? STC_ADDR_CFG_ALT : STC_ADDR_CFG, w);
			i_stc_host_model.wr(STC_ADDR_ONE_SHOT, 8'($urandom));
			chk(one_shot, w[6]);
			i_stc_host_model.rd(i[0] ? STC_ADDR_CFG_ALT : STC_ADDR_CFG, v);
			chk(v, w & STC_CFG_WMASK);
			chk(conv_run, !w[6]);
			chk(pwm_out, (w[6] && w[5]) ? pwm_pol : pwm_in);
		end
		$display("Test configuration and standby done");
		i_stc_host_model.wr(STC_ADDR_CFG, 8'h00);
		i_stc_host_model.wr(STC_ADDR_CRIT, 8'h20);
		cyc(1);
		chk(crit_limit, STC_CRIT_RST);
		w = 8'($urandom);
		i_stc_host_model.wr(STC_ADDR_CFG, 8'h02);
		i_stc_host_model.wr(STC_ADDR_CRIT, w);
		i_stc_host_model.wr(STC_ADDR_CRIT, ~w);
		i_stc_host_model.rd(STC_ADDR_CRIT, v);
		chk(v, w);
		chk(crit_limit, w);
		$display("Test critical limit done");
		for (int m = 0; m < 4; m++) begin
			i_stc_host_model.wr(STC_ADDR_CFG, modes[m]);
			for (int k = 1; k <= 3; k++) begin
				cv(k[0] ? 8'h60 : 8'h05);
				cyc(1);
				chk(pin_oe, (!modes[m][0] || k == 3) && modes[m][7:2] == 6'h00);
				chk(pin_out, 1'b0);
			end
			cv(8'h11 + 8'($urandom % 63));
			cyc(1);
			chk(pin_oe, 1'b0);
		end
		$display("Test fault pin done");
		// Period of 2500 cycles is 20 ticks of 1 us
		repeat (4) begin
			cyc(1250);
			fan = 1'b0;
			cyc(1250);
			fan = 1'b1;
		end
		cyc(100);
		// High byte still frozen by the low read made right after reset
		i_stc_host_model.rd(STC_ADDR_TACH_HI, v);
		chk(v, STC_TACH_RST[15:8]);
		i_stc_host_model.rd(STC_ADDR_TACH_LO, v);
		chk(v >= 8'h13 && v <= 8'h15, 1'b1);
		i_stc_host_model.rd(STC_ADDR_TACH_HI, v);
		chk(v, 8'h00);
		$display("Test fan period done");
		results();
	end
endmodule
`default_nettype wire
